// ==== dv/ptef_frame_tb_top.sv ====
// Self-checking bench of the peripheral frame against a small model.
module ptef_frame_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ptef_pkg::*;
    localparam int ID = 5;
    localparam ptef_word_t BASE = 32'h4000_0000 + ID * 32'h1000;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    ptef_word_t bus_addr, bus_wdata, bus_rdata, mask_m, evt_m, d;
    logic       bus_wr, bus_rd, irq, periph_en;
    logic [3:0] task_in, evt_src, task_fire, evt_out;
    logic [4:0] irq_num;
    int         errors = 0;
    int         check_count = 0;
    int         seed = 32'h268a;
    int         fire_n[4] = '{default: 0};
    int         evo_n[4] = '{default: 0};
    int         fire_x[4] = '{default: 0};
    int         evo_x[4] = '{default: 0};

    ptef_frame #(.PERIPH_ID(ID)) u_ptef_frame (
        .sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .task_in(task_in), .evt_src(evt_src),
        .task_fire(task_fire), .evt_out(evt_out), .irq(irq),
        .irq_num(irq_num), .periph_en(periph_en));
    ptef_peer #(.N(4)) u_ptef_peer (
        .sys_clk(sys_clk), .task_in(task_in), .evt_src(evt_src));

    // Half period of 25 ns gives the 20 MHz clock.
    always #25 sys_clk = ~sys_clk;

    // Counting pulses proves each one lasts exactly one cycle.
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (task_fire[i] === 1'b1) fire_n[i] <= fire_n[i] + 1;
            if (evt_out[i] === 1'b1) evo_n[i] <= evo_n[i] + 1;
        end
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_w(input ptef_word_t got, input ptef_word_t exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t word %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic chk_cnt;
        for (int i = 0; i < 4; i++) begin
            chk_w(fire_n[i], fire_x[i]);
            chk_w(evo_n[i], evo_x[i]);
        end
    endtask

    task automatic wr(input ptef_word_t a, input ptef_word_t v);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input ptef_word_t a, output ptef_word_t v);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask

    task automatic rchk(input ptef_word_t a, input ptef_word_t exp);
        ptef_word_t v;
        rd(a, v);
        chk_w(v, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // The whole run needs a few hundred cycles; this bound is generous.
    initial begin
        #(50 * 20000);
        errors++;
        complete_run();
    end

    initial begin
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        mask_m = '0;
        evt_m = '0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(BASE + 32'h500, 32'h0);
        rchk(BASE + 32'h300, 32'h0);
        rchk(BASE + 32'h200, 32'h0);
        rchk(BASE + 32'h100, 32'h0);
        chk_w({27'h0, irq_num}, ID);
        $display("reset test done");
        u_ptef_peer.pulse(1'b0, 0);
        u_ptef_peer.pulse(1'b1, 1);
        wr(BASE + 32'h004, 32'h1);
        idle(3);
        chk_cnt();
        rchk(BASE + 32'h104, 32'h0);
        wr(BASE + 32'h200, 32'h5);
        rchk(BASE + 32'h200, 32'h5);
        wr(BASE + 32'h500, 32'h1);
        idle(1);
        chk_b(periph_en, 1'b1);
        $display("enable test done");
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(BASE + 32'h304, d);
            mask_m = mask_m | (d & 32'hf);
            rchk(BASE + 32'h300, mask_m);
            rchk(BASE + 32'h304, mask_m);
            d = $random(seed);
            wr(BASE + 32'h308, d);
            mask_m = mask_m & ~d;
            rchk(BASE + 32'h308, mask_m);
        end
        $display("mask test done");
        for (int i = 0; i < 4; i++) begin
            wr(BASE + 4 * i, 32'h1);
            wr(BASE + 4 * i, 32'h2);
            u_ptef_peer.pulse(1'b0, i);
            fire_x[i] += 2;
        end
        idle(2);
        chk_cnt();
        $display("task test done");
        for (int i = 0; i < 4; i++) begin
            repeat (2) u_ptef_peer.pulse(1'b1, i);
            evo_x[i] += 2;
            evt_m[i] = 1'b1;
            if (i % 2 == 0) fire_x[(i + 1) % 4] += 2;
        end
        idle(2);
        chk_cnt();
        wr(BASE + 32'h104, 32'h3);
        for (int i = 0; i < 4; i++) begin
            rchk(BASE + 32'h100 + 4 * i, 32'h1);
        end
        $display("event test done");
        wr(BASE + 32'h304, 32'h1);
        mask_m = mask_m | 32'h1;
        idle(3);
        chk_b(irq, |(evt_m & mask_m));
        for (int i = 0; i < 4; i++) wr(BASE + 32'h100 + 4 * i, 32'h0);
        evt_m = '0;
        rchk(BASE + 32'h10c, 32'h0);
        idle(4);
        chk_b(irq, 1'b0);
        u_ptef_peer.pulse(1'b1, 0);
        evt_m[0] = 1'b1;
        idle(3);
        chk_b(irq, |(evt_m & mask_m));
        wr(BASE + 32'h308, 32'hffff_ffff);
        mask_m = '0;
        idle(4);
        chk_b(irq, 1'b0);
        rchk(BASE + 32'h100, evt_m);
        $display("interrupt test done");
        rchk(BASE + 32'h400, 32'h0);
        wr(BASE - 32'h1000 + 32'h500, 32'h0);
        rchk(BASE - 32'h1000 + 32'h500, 32'h0);
        chk_b(periph_en, 1'b1);
        $display("window test done");
        complete_run();
    end
endmodule

// ==== dv/ptef_peer.sv ====
// Partner peripheral model that pulses the task and event lines.
module ptef_peer #(
    parameter int N = 4
) (
    input  wire logic    sys_clk,
    output logic [N-1:0] task_in,
    output logic [N-1:0] evt_src
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines rest low, so a trigger is seen only when one is meant.
    initial begin
        task_in = '0;
        evt_src = '0;
    end

    // Pulses last one cycle, so the frame acts on each trigger only once.
    task automatic pulse(input bit is_evt, input int idx);
        @(posedge sys_clk);
        if (is_evt) evt_src[idx] <= 1'b1;
        else task_in[idx] <= 1'b1;
        @(posedge sys_clk);
        evt_src <= '0;
        task_in <= '0;
    endtask
endmodule

// ==== verilog/ptef_frame.sv ====
// Task, event, shortcut and interrupt frame of one peripheral.
//
// Design decisions made here: strobed register access and the address map.
`include "ptef_regs.svh"

module ptef_frame #(
    parameter int PERIPH_ID     = 0,
    parameter int N_TASK        = 4,
    parameter int N_EVT         = 4,
    parameter bit HAS_MASK_MAIN = 1'b1
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire ptef_pkg::ptef_word_t bus_addr,
    input  wire ptef_pkg::ptef_word_t bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output ptef_pkg::ptef_word_t    bus_rdata,
    input  wire logic [N_TASK-1:0]  task_in,
    input  wire logic [N_EVT-1:0]   evt_src,
    output logic [N_TASK-1:0]       task_fire,
    output logic [N_EVT-1:0]        evt_out,
    output logic                    irq,
    output logic [4:0]              irq_num,
    output logic                    periph_en
);
    import ptef_pkg::*;

    localparam ptef_word_t WIN_BASE = ptef_word_t'(`PTEF_BUS_BASE
                                      + PERIPH_ID * `PTEF_WIN_BYTES);
    localparam int IRQ_LAG = `PTEF_IRQ_LAG_CYC;

    // Sorts an access into its register group; reads and writes share it.
    function automatic ptef_sel_e ptef_decode(input logic      hit,
                                              input ptef_off_t off);
        ptef_sel_e s;
        s = PTEF_SEL_NONE;
        if (hit) begin
            if (off[11:8] == 4'(`PTEF_OFF_TASK >> 8)) begin
                s = PTEF_SEL_TASK;
            end else if (off[11:8] == 4'(`PTEF_OFF_EVT >> 8)) begin
                s = PTEF_SEL_EVT;
            end else if (off == `PTEF_OFF_SHORT) begin
                s = PTEF_SEL_SHORT;
            end else if (off == `PTEF_OFF_MASK && HAS_MASK_MAIN) begin
                s = PTEF_SEL_MASK;
            end else if (off == `PTEF_OFF_MSET) begin
                s = PTEF_SEL_MSET;
            end else if (off == `PTEF_OFF_MCLR) begin
                s = PTEF_SEL_MCLR;
            end else if (off == `PTEF_OFF_ENABLE) begin
                s = PTEF_SEL_EN;
            end
        end
        return s;
    endfunction

    logic [N_TASK-1:0] task_fire_reg, task_fire_next;
    logic [N_EVT-1:0]  evt_out_reg,   evt_out_next;
    logic [N_EVT-1:0]  evt_reg,       evt_next;
    logic [N_EVT-1:0]  mask_reg,      mask_next;
    logic [N_EVT-1:0]  short_reg,     short_next;
    logic              en_reg,        en_next;
    logic              irq_reg,       irq_next;
    ptef_word_t        rdata_reg,     rdata_next;
    logic [4:0]        irq_num_reg;

    logic              in_win;
    ptef_off_t         off;
    ptef_sel_e         w_sel;
    ptef_sel_e         r_sel;
    logic [N_TASK-1:0] sw_task;
    logic [N_TASK-1:0] short_task;
    logic [N_EVT-1:0]  evt_gen;
    logic [N_EVT-1:0]  evt_clr;
    logic              irq_cause;

    // Address decode: only the upper bits pick the window, the rest the word.
    assign in_win = bus_addr[31:`PTEF_WIN_LSB]
                    == WIN_BASE[31:`PTEF_WIN_LSB];
    assign off    = bus_addr[11:0];
    assign w_sel  = bus_wr ? ptef_decode(in_win, off) : PTEF_SEL_NONE;
    assign r_sel  = bus_rd ? ptef_decode(in_win, off) : PTEF_SEL_NONE;

    // A shift keeps out-of-range task or event words harmless.
    assign sw_task = (w_sel == PTEF_SEL_TASK
                      && bus_wdata == `PTEF_TASK_GO_VAL)
                     ? N_TASK'(1) << off[9:2] : '0;
    assign evt_clr = (w_sel == PTEF_SEL_EVT && bus_wdata == '0)
                     ? N_EVT'(1) << off[7:2] : '0;

    // A disabled peripheral swallows events before anything sees them.
    assign evt_gen = en_reg ? evt_src : '0;

    // Event i is wired to task (i+1) mod N_TASK; the link itself can never be moved.
    always_comb begin
        short_task = '0;
        for (int i = 0; i < N_EVT; i++) begin
            if (short_reg[i] && evt_gen[i]) begin
                short_task[(i + 1) % N_TASK] = 1'b1;
            end
        end
    end

    // Task and event pulse outputs, registered and high for as many cycles as their trigger.
    always_comb begin
        task_fire_next = en_reg ? (sw_task | task_in | short_task)
                                : '0;
        evt_out_next   = evt_gen;
    end

    // Event registers: a new event in the clearing cycle wins.
    always_comb begin
        evt_next = (evt_reg & ~evt_clr) | evt_gen;
    end

    // Mask word with its aliases; aliases act on the ones only.
    always_comb begin
        mask_next = mask_reg;
        if (w_sel == PTEF_SEL_MASK) begin
            mask_next = bus_wdata[N_EVT-1:0];
        end
        if (w_sel == PTEF_SEL_MSET) begin
            mask_next = mask_reg | bus_wdata[N_EVT-1:0];
        end
        if (w_sel == PTEF_SEL_MCLR) begin
            mask_next = mask_reg & ~bus_wdata[N_EVT-1:0];
        end
    end

    // Shortcut enables and the peripheral enable.
    always_comb begin
        short_next = short_reg;
        en_next    = en_reg;
        if (w_sel == PTEF_SEL_SHORT) begin
            short_next = bus_wdata[N_EVT-1:0];
        end
        if (w_sel == PTEF_SEL_EN) begin
            en_next = bus_wdata[`PTEF_ENABLE_BIT];
        end
    end

    // Level interrupt from stored state; one register stage keeps it glitch
    // free at the cost of a cycle, well inside the allowed lag.
    assign irq_cause = |(evt_reg & mask_reg);
    always_comb begin
        irq_next = irq_cause;
    end

    // Read mux; anything unmapped or outside the window reads zero.
    always_comb begin
        rdata_next = '0;
        unique case (r_sel)
            PTEF_SEL_NONE:  rdata_next = '0;
            PTEF_SEL_TASK:  rdata_next = '0;
            PTEF_SEL_EVT:   rdata_next = ptef_word_t'(evt_reg >> off[7:2])
                                         & 32'h0000_0001;
            PTEF_SEL_SHORT: rdata_next = ptef_word_t'(short_reg);
            PTEF_SEL_MASK:  rdata_next = ptef_word_t'(mask_reg);
            PTEF_SEL_MSET:  rdata_next = ptef_word_t'(mask_reg);
            PTEF_SEL_MCLR:  rdata_next = ptef_word_t'(mask_reg);
            PTEF_SEL_EN:    rdata_next = ptef_word_t'(en_reg);
        endcase
    end

    // State registers only; all next values except irq_num_reg come from the blocks above.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            task_fire_reg <= '0;
            evt_out_reg   <= '0;
            evt_reg       <= '0;
            mask_reg      <= '0;
            short_reg     <= '0;
            en_reg        <= `PTEF_RST_EN;
            irq_reg       <= 1'b0;
            rdata_reg     <= `PTEF_RST_WORD;
            irq_num_reg   <= 5'(PERIPH_ID);
        end else begin
            task_fire_reg <= task_fire_next;
            evt_out_reg   <= evt_out_next;
            evt_reg       <= evt_next;
            mask_reg      <= mask_next;
            short_reg     <= short_next;
            en_reg        <= en_next;
            irq_reg       <= irq_next;
            rdata_reg     <= rdata_next;
            irq_num_reg   <= 5'(PERIPH_ID);
        end
    end

    assign task_fire = task_fire_reg;
    assign evt_out   = evt_out_reg;
    assign irq       = irq_reg;
    assign irq_num   = irq_num_reg;
    assign periph_en = en_reg;
    assign bus_rdata = rdata_reg;

    // Checks on the frame.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_evt0_in;
        en_reg && evt_src[0];
    endsequence

    sequence s_short0_hit;
        s_evt0_in ##0 short_reg[0];
    endsequence

    sequence s_sw_task0;
        en_reg && w_sel == PTEF_SEL_TASK && off[9:2] == 8'h00
        && bus_wdata == `PTEF_TASK_GO_VAL;
    endsequence

    a_task_sw_fire: assert property (
        s_sw_task0 |=> task_fire[0])
        else $error("Software task write did not fire the task.");

    // A second high cycle is legal only when a fresh trigger came in.
    a_task_once: assert property (
        s_sw_task0 ##1 !(task_in[0] || sw_task[0] || short_task[0])
        |=> !task_fire[0])
        else $error("Task pulse lasted longer than one cycle.");

    a_task_hw_fire: assert property (
        en_reg && task_in[0] |=> task_fire[0])
        else $error("Hardware task pulse did not fire the task.");

    a_evt_capture: assert property (
        s_evt0_in |=> evt_out[0] && evt_reg[0])
        else $error("Event pulse was not passed on and stored.");

    a_idle_no_evt: assert property (
        !en_reg && !evt_reg[1] |=> !evt_reg[1])
        else $error("Disabled peripheral stored an event.");

    a_irq_number: assert property (
        irq_num == 5'(PERIPH_ID))
        else $error("Interrupt number differs from the identifier.");

    a_idle_no_task: assert property (
        !en_reg |=> task_fire == '0 && evt_out == '0)
        else $error("Disabled peripheral produced a task or event.");

    a_short_fire: assert property (
        s_short0_hit |=> task_fire[1 % N_TASK])
        else $error("Enabled shortcut did not fire its task.");

    a_evt_regen: assert property (
        s_evt0_in ##0 evt_reg[0] |=> evt_out[0] && evt_reg[0])
        else $error("Event lost while its register was already set.");

    a_evt_sticky: assert property (
        evt_reg[0] && !evt_clr[0] |=> evt_reg[0])
        else $error("Event register dropped without a zero write.");

    a_evt_clear: assert property (
        evt_reg[0] && evt_clr[0] && !evt_gen[0] |=> !evt_reg[0])
        else $error("Zero write did not clear the event register.");

    a_mask_alias: assert property (
        w_sel == PTEF_SEL_MSET && bus_wdata[0] |=> mask_reg[0]
        ##1 (mask_reg[0] || $past(w_sel) == PTEF_SEL_MCLR
             || $past(w_sel) == PTEF_SEL_MASK))
        else $error("Set alias did not set the mask bit.");

    a_mask_clr: assert property (
        w_sel == PTEF_SEL_MCLR && bus_wdata[0] |=> !mask_reg[0])
        else $error("Clear alias did not clear the mask bit.");

    a_alias_read: assert property (
        r_sel == PTEF_SEL_MCLR || r_sel == PTEF_SEL_MSET
        |=> bus_rdata == ptef_word_t'($past(mask_reg)))
        else $error("Alias read did not return the mask.");

    a_irq_level: assert property (
        irq_cause |=> irq)
        else $error("Interrupt low while a masked-in event is set.");

    a_irq_drop: assert property (
        !irq_cause [*2] |-> ##[0:IRQ_LAG] !irq)
        else $error("Interrupt stayed high after its cause went away.");

    a_win_outside: assert property (
        bus_rd && !in_win |=> bus_rdata == '0)
        else $error("Read outside the window returned data.");

endmodule

// ==== verilog/ptef_pkg.sv ====
// Types shared by the peripheral frame.
package ptef_pkg;

    typedef logic [31:0] ptef_word_t;
    typedef logic [11:0] ptef_off_t;

    // Register group selected by one bus access, one-hot.
    typedef enum logic [7:0] {
        PTEF_SEL_NONE  = 8'h01,
        PTEF_SEL_TASK  = 8'h02,
        PTEF_SEL_EVT   = 8'h04,
        PTEF_SEL_SHORT = 8'h08,
        PTEF_SEL_MASK  = 8'h10,
        PTEF_SEL_MSET  = 8'h20,
        PTEF_SEL_MCLR  = 8'h40,
        PTEF_SEL_EN    = 8'h80
    } ptef_sel_e;

endpackage

// ==== verilog/ptef_regs.svh ====
// Register offsets, reset values and timing figures of the peripheral frame.
`ifndef PTEF_REGS_SVH
`define PTEF_REGS_SVH

// Window placement on the peripheral bus.
`define PTEF_BUS_BASE     32'h4000_0000
`define PTEF_WIN_BYTES    32'h0000_1000
`define PTEF_WIN_LSB      12

// Byte offsets inside the window.
`define PTEF_OFF_TASK     12'h000
`define PTEF_OFF_EVT      12'h100
`define PTEF_OFF_SHORT    12'h200
`define PTEF_OFF_MASK     12'h300
`define PTEF_OFF_MSET     12'h304
`define PTEF_OFF_MCLR     12'h308
`define PTEF_OFF_ENABLE   12'h500

// Field positions and values.
`define PTEF_ENABLE_BIT   0
`define PTEF_TASK_GO_VAL  32'h0000_0001

// Reset values.
`define PTEF_RST_WORD     32'h0000_0000
`define PTEF_RST_EN       1'b0

// Longest delay from a clear or a mask to the interrupt dropping, cycles.
`define PTEF_IRQ_LAG_CYC  4

`endif
